// *** include/iolp_params.svh ***
`ifndef IOLP_PARAMS_SVH
`define IOLP_PARAMS_SVH
`define IOLP_NUM_LINES 15
`define IOLP_PORT_BASE 10
`define IOLP_LAST_PASS_LINE 13
`define IOLP_NUM_DIRECT 8
`define IOLP_NUM_TIMERS 16
`define IOLP_PWM_TIMER 15
`define IOLP_CFG_OUT_HIGH 3'h4
`define IOLP_CFG_OUT_LOW 3'h5
`define IOLP_BCAST_ADDR 64'h0000_0000_0000_ffff
`define IOLP_TICK_MS 100
`define IOLP_CLK_KHZ 25000
`define IOLP_TICK_CYCLES (`IOLP_TICK_MS * `IOLP_CLK_KHZ)
`define IOLP_TIMEOUT_W 16
`define IOLP_DUTY_W 10
`define IOLP_TICK_W 24
`define IOLP_DIRECT_RST 8'h00
`define IOLP_DUTY_RST 10'h000
`endif

// *** include/iolp_pkg.sv ***
`include "iolp_params.svh"
package iolp_pkg;
  typedef logic [2:0] iolp_cfg_t;
  typedef logic [`IOLP_TIMEOUT_W-1:0] iolp_timeout_t;
  typedef logic [`IOLP_DUTY_W-1:0] iolp_duty_t;
  typedef enum logic [2:0] {
    IOLP_AWAKE  = 3'b001,
    IOLP_ASLEEP = 3'b010,
    IOLP_WAKING = 3'b100
  } iolp_sleep_state_t;
endpackage

// *** include/iolp_timer_if.sv ***
interface iolp_timer_if;
  import iolp_pkg::*;
  logic load;
  iolp_timeout_t loadValue;
  logic tick;
  logic active;
  modport owner (output load, output loadValue, output tick, input active);
  modport timer (input load, input loadValue, input tick, output active);
endinterface

// *** hdl/iolp_hold_timer.sv ***
`include "iolp_params.svh"
module iolp_hold_timer
  import iolp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  iolp_timer_if.timer t
);
  iolp_timeout_t count_reg;
  iolp_timeout_t count_next;

  // a fresh load restarts the hold even if one is already running
  always_comb begin
    count_next = count_reg;
    if (t.load) begin
      count_next = t.loadValue;
    end else if (t.tick && (count_reg != '0)) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign t.active = (count_reg != '0);
endmodule

// *** hdl/iolp_line_passing.sv ***
`include "iolp_params.svh"
module iolp_line_passing
  import iolp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `IOLP_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleValid,
  input wire logic [63:0] sampleSrcAddr,
  input wire logic [15:0] sampleDigMask,
  input wire logic [15:0] sampleDigData,
  input wire logic [1:0] sampleAnaMask,
  input wire iolp_duty_t sampleAnalog0,
  input wire iolp_duty_t sampleAnalog1,
  input wire logic [63:0] boundSourceAddress,
  input wire logic [`IOLP_NUM_LINES-1:0][2:0] lineCfg,
  input wire logic [`IOLP_NUM_LINES-1:0] serialPinMask,
  input wire iolp_timeout_t [9:0] digitalLineTimeout,
  input wire iolp_timeout_t [4:0] portLineTimeout,
  input wire iolp_timeout_t pwmHoldTimeout,
  input wire iolp_duty_t pwm0PresetDuty,
  input wire iolp_duty_t pwm1PresetDuty,
  input wire logic forwardSampleToSerial,
  input wire logic framedMode,
  input wire logic directWrite,
  input wire logic [`IOLP_NUM_DIRECT-1:0] directOutputLevel,
  input wire logic sleepActive,
  input wire logic [`IOLP_NUM_LINES-1:0] pullResistorEnable,
  input wire logic [`IOLP_NUM_LINES-1:0] pullDirection,
  output logic [`IOLP_NUM_LINES-1:0] lineOut,
  output logic [`IOLP_NUM_LINES-1:0] lineOe,
  output logic [`IOLP_NUM_LINES-1:0] linePullUp,
  output logic [`IOLP_NUM_LINES-1:0] linePullDown,
  output iolp_duty_t pulseOutput0Duty,
  output iolp_duty_t pulseOutput1Duty,
  output logic sampleFrameEmit,
  output logic changeDetectTrigger,
  output logic periphForceLow,
  output logic spiForceHigh
);

  // ************************************************
  // decode helpers
  // ************************************************
  function automatic logic iolp_is_output(input iolp_cfg_t cfg);
    return (cfg == `IOLP_CFG_OUT_HIGH) || (cfg == `IOLP_CFG_OUT_LOW);
  endfunction

  function automatic logic iolp_cfg_level(input iolp_cfg_t cfg);
    return (cfg == `IOLP_CFG_OUT_HIGH);
  endfunction

  // ************************************************
  // sleep phase and timeout tick
  // ************************************************
  iolp_sleep_state_t sleepState_reg;
  iolp_sleep_state_t sleepState_next;
  logic [`IOLP_TICK_W-1:0] tickCnt_reg;
  logic [`IOLP_TICK_W-1:0] tickCnt_next;
  logic tick_reg;
  logic tick_next;
  logic asleep;
  logic waking;

  assign asleep = (sleepState_reg == IOLP_ASLEEP);
  assign waking = (sleepState_reg == IOLP_WAKING);

  always_comb begin
    sleepState_next = sleepState_reg;
    case (sleepState_reg)
      IOLP_AWAKE: begin
        if (sleepActive) begin
          sleepState_next = IOLP_ASLEEP;
        end
      end
      IOLP_ASLEEP: begin
        if (!sleepActive) begin
          sleepState_next = IOLP_WAKING;
        end
      end
      IOLP_WAKING: begin
        sleepState_next = sleepActive ? IOLP_ASLEEP : IOLP_AWAKE;
      end
      default: begin
        sleepState_next = IOLP_AWAKE;
      end
    endcase
  end

  // the prescaler freezes in sleep so hold times resume where they stopped
  always_comb begin
    tickCnt_next = tickCnt_reg;
    tick_next = 1'b0;
    if (!asleep) begin
      if (tickCnt_reg == `IOLP_TICK_W'(TICK_CYCLES - 1)) begin
        tickCnt_next = '0;
        tick_next = 1'b1;
      end else begin
        tickCnt_next = tickCnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepState_reg <= IOLP_AWAKE;
      tickCnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      sleepState_reg <= sleepState_next;
      tickCnt_reg <= tickCnt_next;
      tick_reg <= tick_next;
    end
  end

  // ************************************************
  // sample acceptance
  // ************************************************
  logic srcMatch;
  logic pwmLoad;
  logic [`IOLP_NUM_LINES-1:0] passAllowed;
  logic [`IOLP_NUM_LINES-1:0] passLoad;
  logic [`IOLP_NUM_LINES-1:0] isOut;
  iolp_timeout_t [`IOLP_NUM_LINES-1:0] lineTimeout;

  // accepted in either serial mode; framing only affects forwarding
  always_comb begin
    srcMatch = sampleValid && ((sampleSrcAddr == boundSourceAddress) ||
               (boundSourceAddress == `IOLP_BCAST_ADDR));
    pwmLoad = srcMatch && (sampleAnaMask != 2'h0);
    // main lines fill slots 0-9, port lines the slots above
    lineTimeout = {portLineTimeout, digitalLineTimeout};
    for (int i = 0; i < `IOLP_NUM_LINES; i++) begin
      isOut[i] = iolp_is_output(lineCfg[i]);
      passAllowed[i] = (i <= `IOLP_LAST_PASS_LINE) && !serialPinMask[i] && isOut[i];
      passLoad[i] = srcMatch && sampleDigMask[i] && passAllowed[i];
    end
  end

  // ************************************************
  // hold timers, one per line plus one shared by the pulse outputs
  // ************************************************
  iolp_timer_if tmr[`IOLP_NUM_TIMERS] ();
  logic [`IOLP_NUM_TIMERS-1:0] holdActive;

  generate
    for (genvar g = 0; g < `IOLP_NUM_TIMERS; g++) begin : gen_timer
      if (g == `IOLP_PWM_TIMER) begin : gen_pwm
        assign tmr[g].load = pwmLoad;
        assign tmr[g].loadValue = pwmHoldTimeout;
      end else begin : gen_line
        assign tmr[g].load = passLoad[g];
        assign tmr[g].loadValue = lineTimeout[g];
      end
      assign tmr[g].tick = tick_reg;
      assign holdActive[g] = tmr[g].active;
      iolp_hold_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .t(tmr[g])
      );
    end
  endgenerate

  // ************************************************
  // digital lines
  // ************************************************
  logic [`IOLP_NUM_LINES-1:0] passLevel_reg;
  logic [`IOLP_NUM_LINES-1:0] passLevel_next;
  logic [`IOLP_NUM_DIRECT-1:0] directLevel_reg;
  logic [`IOLP_NUM_DIRECT-1:0] directLevel_next;
  logic [`IOLP_NUM_DIRECT-1:0] directSet_reg;
  logic [`IOLP_NUM_DIRECT-1:0] directSet_next;
  logic [`IOLP_NUM_LINES-1:0] lineOut_reg;
  logic [`IOLP_NUM_LINES-1:0] lineOut_next;
  logic [`IOLP_NUM_LINES-1:0] lineOe_reg;
  logic [`IOLP_NUM_LINES-1:0] lineOe_next;
  logic [`IOLP_NUM_LINES-1:0] pullUp_reg;
  logic [`IOLP_NUM_LINES-1:0] pullUp_next;
  logic [`IOLP_NUM_LINES-1:0] pullDown_reg;
  logic [`IOLP_NUM_LINES-1:0] pullDown_next;
  logic changeDetect_reg;
  logic changeDetect_next;

  // sleep needs no special case here: outputs already hold and the
  // remaining lines already follow their pulls
  always_comb begin
    passLevel_next = passLevel_reg;
    directLevel_next = directLevel_reg;
    directSet_next = directSet_reg;
    changeDetect_next = 1'b0;
    if (directWrite) begin
      directLevel_next = directOutputLevel;
      directSet_next = '1;
      changeDetect_next = |((directOutputLevel ^ lineOut_reg[`IOLP_NUM_DIRECT-1:0]) &
                            isOut[`IOLP_NUM_DIRECT-1:0]);
    end
    for (int i = 0; i < `IOLP_NUM_LINES; i++) begin
      logic baseLevel;
      baseLevel = iolp_cfg_level(lineCfg[i]);
      if (passLoad[i]) begin
        passLevel_next[i] = sampleDigData[i];
      end
      if (i < `IOLP_NUM_DIRECT) begin
        if (directSet_reg[i]) begin
          baseLevel = directLevel_reg[i];
        end
      end
      lineOe_next[i] = isOut[i];
      lineOut_next[i] = isOut[i] && (holdActive[i] ? passLevel_reg[i] : baseLevel);
      pullUp_next[i] = !isOut[i] && pullResistorEnable[i] && pullDirection[i];
      pullDown_next[i] = !isOut[i] && pullResistorEnable[i] && !pullDirection[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      passLevel_reg <= '0;
      directLevel_reg <= `IOLP_DIRECT_RST;
      directSet_reg <= '0;
      lineOut_reg <= '0;
      lineOe_reg <= '0;
      pullUp_reg <= '0;
      pullDown_reg <= '0;
      changeDetect_reg <= 1'b0;
    end else begin
      passLevel_reg <= passLevel_next;
      directLevel_reg <= directLevel_next;
      directSet_reg <= directSet_next;
      lineOut_reg <= lineOut_next;
      lineOe_reg <= lineOe_next;
      pullUp_reg <= pullUp_next;
      pullDown_reg <= pullDown_next;
      changeDetect_reg <= changeDetect_next;
    end
  end

  // ************************************************
  // pulse outputs
  // ************************************************
  iolp_duty_t [1:0] pwmPass_reg;
  iolp_duty_t [1:0] pwmPass_next;
  logic [1:0] pwmDriven_reg;
  logic [1:0] pwmDriven_next;
  iolp_duty_t [1:0] pwmDuty_reg;
  iolp_duty_t [1:0] pwmDuty_next;
  iolp_duty_t [1:0] pwmPreset;
  iolp_duty_t [1:0] anaSample;

  // analog full scale equals duty full scale, so the value maps one to one
  assign anaSample[0] = sampleAnalog0;
  assign anaSample[1] = sampleAnalog1;
  assign pwmPreset[0] = pwm0PresetDuty;
  assign pwmPreset[1] = pwm1PresetDuty;

  always_comb begin
    pwmPass_next = pwmPass_reg;
    pwmDriven_next = pwmDriven_reg;
    for (int k = 0; k < 2; k++) begin
      if (pwmLoad && sampleAnaMask[k]) begin
        pwmPass_next[k] = anaSample[k];
        pwmDriven_next[k] = 1'b1;
      end else if (waking) begin
        pwmDriven_next[k] = 1'b0;
      end else if (!holdActive[`IOLP_PWM_TIMER] && !pwmLoad) begin
        pwmDriven_next[k] = 1'b0;
      end
      if (asleep) begin
        pwmDuty_next[k] = `IOLP_DUTY_RST;
      end else if (pwmDriven_reg[k] && !waking) begin
        pwmDuty_next[k] = pwmPass_reg[k];
      end else begin
        pwmDuty_next[k] = pwmPreset[k];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmPass_reg <= '0;
      pwmDriven_reg <= '0;
      pwmDuty_reg <= '0;
    end else begin
      pwmPass_reg <= pwmPass_next;
      pwmDriven_reg <= pwmDriven_next;
      pwmDuty_reg <= pwmDuty_next;
    end
  end

  // ************************************************
  // serial forwarding and sleep pin control
  // ************************************************
  logic frame_reg;
  logic frame_next;
  logic periphLow_reg;
  logic periphLow_next;
  logic spiHigh_reg;
  logic spiHigh_next;

  // transparent mode never frames samples; it only passes lines and pulse duties
  always_comb begin
    frame_next = sampleValid && framedMode && (!srcMatch || forwardSampleToSerial);
    periphLow_next = asleep;
    spiHigh_next = asleep;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= 1'b0;
      periphLow_reg <= 1'b0;
      spiHigh_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      periphLow_reg <= periphLow_next;
      spiHigh_reg <= spiHigh_next;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign lineOut = lineOut_reg;
  assign lineOe = lineOe_reg;
  assign linePullUp = pullUp_reg;
  assign linePullDown = pullDown_reg;
  assign pulseOutput0Duty = pwmDuty_reg[0];
  assign pulseOutput1Duty = pwmDuty_reg[1];
  assign sampleFrameEmit = frame_reg;
  assign changeDetectTrigger = changeDetect_reg;
  assign periphForceLow = periphLow_reg;
  assign spiForceHigh = spiHigh_reg;
endmodule

// *** tb/iolp_line_passing_checker.sv ***
`include "iolp_params.svh"
module iolp_lp_checker
  import iolp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `IOLP_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleValid,
  input wire logic [63:0] sampleSrcAddr,
  input wire logic [15:0] sampleDigMask,
  input wire logic [15:0] sampleDigData,
  input wire logic [63:0] boundSourceAddress,
  input wire logic [`IOLP_NUM_LINES-1:0][2:0] lineCfg,
  input wire logic [`IOLP_NUM_LINES-1:0] serialPinMask,
  input wire iolp_duty_t pwm0PresetDuty,
  input wire iolp_duty_t pwm1PresetDuty,
  input wire logic forwardSampleToSerial,
  input wire logic framedMode,
  input wire logic directWrite,
  input wire logic sleepActive,
  input wire logic [`IOLP_NUM_LINES-1:0] lineOut,
  input wire logic [`IOLP_NUM_LINES-1:0] lineOe,
  input wire iolp_duty_t pulseOutput0Duty,
  input wire iolp_duty_t pulseOutput1Duty,
  input wire logic sampleFrameEmit,
  input wire logic changeDetectTrigger,
  input wire logic periphForceLow,
  input wire logic spiForceHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic isMatch;
  logic [`IOLP_NUM_LINES-1:0] isOut;
  logic [`IOLP_NUM_LINES-1:0] passable;
  // only lines that the sample carries and that may be passed
  always_comb begin
    isMatch = (boundSourceAddress == `IOLP_BCAST_ADDR) || (sampleSrcAddr == boundSourceAddress);
    for (int i = 0; i < `IOLP_NUM_LINES; i++) begin
      isOut[i] = (lineCfg[i] == `IOLP_CFG_OUT_HIGH) || (lineCfg[i] == `IOLP_CFG_OUT_LOW);
      passable[i] = isOut[i] && !serialPinMask[i] && (i <= `IOLP_LAST_PASS_LINE) && sampleDigMask[i];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_asleep; sleepActive [*2]; endsequence
  sequence s_woken; s_asleep ##1 !sleepActive [*2]; endsequence
  property p_frame_foreign; sampleValid && framedMode && !isMatch |=> sampleFrameEmit; endproperty
  a_frame_foreign: assert property (p_frame_foreign) else $error("foreign sample not framed");
  property p_frame_off; sampleValid && isMatch && !forwardSampleToSerial |=> !sampleFrameEmit; endproperty
  a_frame_off: assert property (p_frame_off) else $error("suppressed frame emitted");
  property p_transparent; sampleValid && !framedMode |=> !sampleFrameEmit; endproperty
  a_transparent: assert property (p_transparent) else $error("frame in transparent mode");
  property p_frame_cause; sampleFrameEmit |-> $past(sampleValid) && $past(framedMode); endproperty
  a_frame_cause: assert property (p_frame_cause) else $error("frame without sample");
  property p_pass;
    sampleValid && isMatch && !sleepActive |-> ##2 ((lineOut ^ $past(sampleDigData, 2)) & $past(passable, 2)) == '0;
  endproperty
  a_pass: assert property (p_pass) else $error("passed level wrong");
  property p_oe; ($stable(lineCfg)) [*2] |=> lineOe == isOut; endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");
  property p_sleep_pwm; s_asleep |=> pulseOutput0Duty == '0 && pulseOutput1Duty == '0; endproperty
  a_sleep_pwm: assert property (p_sleep_pwm) else $error("pulse not low asleep");
  property p_sleep_force; s_asleep |=> periphForceLow && spiForceHigh; endproperty
  a_sleep_force: assert property (p_sleep_force) else $error("pin force missing asleep");
  property p_wake;
    s_woken |=> pulseOutput0Duty == pwm0PresetDuty && pulseOutput1Duty == pwm1PresetDuty && !periphForceLow;
  endproperty
  a_wake: assert property (p_wake) else $error("wake state wrong");
  property p_trig; changeDetectTrigger |-> $past(directWrite); endproperty
  a_trig: assert property (p_trig) else $error("trigger without write");
endmodule
bind iolp_line_passing iolp_lp_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk, .rst_n, .sampleValid,
  .sampleSrcAddr, .sampleDigMask, .sampleDigData, .boundSourceAddress, .lineCfg, .serialPinMask,
  .pwm0PresetDuty, .pwm1PresetDuty, .forwardSampleToSerial, .framedMode, .directWrite, .sleepActive, .lineOut,
  .lineOe, .pulseOutput0Duty, .pulseOutput1Duty, .sampleFrameEmit, .changeDetectTrigger, .periphForceLow,
  .spiForceHigh);

// *** tb/iolp_node_model.sv ***
module iolp_node_model
  import iolp_pkg::*;
(
  input wire logic clk,
  output logic sampleValid,
  output logic [63:0] sampleSrcAddr,
  output logic [15:0] sampleDigMask,
  output logic [15:0] sampleDigData,
  output logic [1:0] sampleAnaMask,
  output iolp_duty_t sampleAnalog0,
  output iolp_duty_t sampleAnalog1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sampleValid = 1'b0;
    {sampleSrcAddr, sampleDigMask, sampleDigData, sampleAnaMask, sampleAnalog0, sampleAnalog1} = '0;
  end
  // one sample per call, as a change-detect or periodic event would send it
  task automatic send(input logic [63:0] a, input logic [15:0] m, input logic [15:0] d, input logic [1:0] am,
                      input iolp_duty_t v0, input iolp_duty_t v1);
    @(posedge clk);
    #1;
    sampleValid = 1'b1;
    {sampleSrcAddr, sampleDigMask, sampleDigData, sampleAnaMask, sampleAnalog0, sampleAnalog1} = {a, m, d, am, v0, v1};
    @(posedge clk);
    #1;
    sampleValid = 1'b0;
    // stale payload is inverted so nothing can lean on it
    {sampleSrcAddr, sampleDigMask, sampleDigData, sampleAnaMask, sampleAnalog0, sampleAnalog1} =
      ~{a, m, d, am, v0, v1};
  endtask
endmodule

// *** tb/iolp_line_passing_tb.sv ***
`include "iolp_params.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module iolp_line_passing_tb;
  import iolp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] SRC = 64'h0000_0000_0000_0a5c;
  localparam logic [63:0] OTHER = 64'h0000_0000_0000_0b71;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  logic sampleValid, forwardSampleToSerial, framedMode, directWrite, sleepActive;
  logic [63:0] sampleSrcAddr, boundSourceAddress;
  logic [15:0] sampleDigMask, sampleDigData;
  logic [1:0] sampleAnaMask;
  iolp_duty_t sampleAnalog0, sampleAnalog1, pwm0PresetDuty, pwm1PresetDuty, pulseOutput0Duty, pulseOutput1Duty;
  logic [14:0][2:0] lineCfg;
  logic [14:0] serialPinMask, pullResistorEnable, pullDirection, lineOut, lineOe, linePullUp, linePullDown;
  iolp_timeout_t [9:0] digitalLineTimeout;
  iolp_timeout_t [4:0] portLineTimeout;
  iolp_timeout_t pwmHoldTimeout;
  logic [7:0] directOutputLevel;
  logic sampleFrameEmit, changeDetectTrigger, periphForceLow, spiForceHigh;
  always #20 clk = ~clk;
  iolp_node_model u_node (.clk, .sampleValid, .sampleSrcAddr, .sampleDigMask, .sampleDigData, .sampleAnaMask,
    .sampleAnalog0, .sampleAnalog1);
  iolp_line_passing #(.TICK_CYCLES(4)) u_dut (.clk, .rst_n, .sampleValid, .sampleSrcAddr, .sampleDigMask,
    .sampleDigData, .sampleAnaMask, .sampleAnalog0, .sampleAnalog1, .boundSourceAddress, .lineCfg, .serialPinMask,
    .digitalLineTimeout, .portLineTimeout, .pwmHoldTimeout, .pwm0PresetDuty, .pwm1PresetDuty,
    .forwardSampleToSerial, .framedMode, .directWrite, .directOutputLevel, .sleepActive, .pullResistorEnable,
    .pullDirection, .lineOut, .lineOe, .linePullUp, .linePullDown, .pulseOutput0Duty, .pulseOutput1Duty,
    .sampleFrameEmit, .changeDetectTrigger, .periphForceLow, .spiForceHigh);
  // ************************************************
  // tasks
  // ************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic dwrite(input logic [7:0] v);
    directOutputLevel = v;
    directWrite = 1'b1;
    @(posedge clk);
    #1;
    directWrite = 1'b0;
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ************************************************
  // tests
  // ************************************************
  initial begin
    // outputs: 2,11,12,14 low, 3 high; line 1 input; line 12 serves the serial port
    lineCfg = '0;
    lineCfg[1] = 3'h3;
    {lineCfg[2], lineCfg[11], lineCfg[12], lineCfg[14]} = {4{`IOLP_CFG_OUT_LOW}};
    lineCfg[3] = `IOLP_CFG_OUT_HIGH;
    for (int i = 0; i < 10; i++) digitalLineTimeout[i] = 16'h0003;
    for (int i = 0; i < 5; i++) portLineTimeout[i] = 16'h0008;
    {serialPinMask, pullResistorEnable, pullDirection} = {15'h1000, 15'h0003, 15'h0002};
    {boundSourceAddress, pwmHoldTimeout, pwm0PresetDuty, pwm1PresetDuty} = {SRC, 16'h0002, 10'h055, 10'h0aa};
    {forwardSampleToSerial, framedMode, directWrite, sleepActive, directOutputLevel} = {4'b1100, 8'h00};
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(3);
    `CHK("lineOe", 15'h580c, lineOe)
    `CHK("lineOut", 15'h0008, lineOut)
    `CHK("linePullUp", 15'h0002, linePullUp)
    `CHK("linePullDown", 15'h0001, linePullDown)
    `CHK("duty0", 10'h055, pulseOutput0Duty)
    u_node.send(SRC, 16'h5806, 16'hffff, 2'b00, 10'h000, 10'h000);
    `CHK("frame", 1'b1, sampleFrameEmit)
    cyc(1);
    `CHK("lineOut", 15'h080c, lineOut)
    cyc(6);
    `CHK("lineOut", 15'h080c, lineOut)
    cyc(14);
    `CHK("lineOut", 15'h0808, lineOut)
    cyc(20);
    `CHK("lineOut", 15'h0008, lineOut)
    forwardSampleToSerial = 1'b0;
    u_node.send(OTHER, 16'h0004, 16'h0004, 2'b00, 10'h000, 10'h000);
    `CHK("frame", 1'b1, sampleFrameEmit)
    cyc(1);
    `CHK("lineOut", 15'h0008, lineOut)
    u_node.send(SRC, 16'h0008, 16'h0000, 2'b00, 10'h000, 10'h000);
    `CHK("frame", 1'b0, sampleFrameEmit)
    cyc(1);
    `CHK("lineOut", 15'h0000, lineOut)
    {framedMode, forwardSampleToSerial} = 2'b01;
    u_node.send(SRC, 16'h0004, 16'h0004, 2'b00, 10'h000, 10'h000);
    `CHK("frame", 1'b0, sampleFrameEmit)
    cyc(1);
    `CHK("lineOut", 15'h0004, lineOut)
    framedMode = 1'b1;
    cyc(20);
    boundSourceAddress = `IOLP_BCAST_ADDR;
    u_node.send(OTHER, 16'h0004, 16'h0004, 2'b00, 10'h000, 10'h000);
    `CHK("frame", 1'b1, sampleFrameEmit)
    cyc(1);
    `CHK("lineOut", 15'h000c, lineOut)
    boundSourceAddress = SRC;
    cyc(20);
    u_node.send(SRC, 16'h0000, 16'h0000, 2'b11, 10'h3d0, 10'h124);
    cyc(1);
    `CHK("duty0", 10'h3d0, pulseOutput0Duty)
    `CHK("duty1", 10'h124, pulseOutput1Duty)
    cyc(16);
    `CHK("duty0", 10'h055, pulseOutput0Duty)
    `CHK("duty1", 10'h0aa, pulseOutput1Duty)
    dwrite(8'h06);
    `CHK("trigger", 1'b1, changeDetectTrigger)
    cyc(1);
    `CHK("lineOut", 15'h0004, lineOut)
    cyc(40);
    `CHK("lineOut", 15'h0004, lineOut)
    dwrite(8'h0c);
    cyc(2);
    `CHK("lineOut", 15'h000c, lineOut)
    dwrite(8'h0c);
    `CHK("trigger", 1'b0, changeDetectTrigger)
    // a long pulse hold shows that wake restores presets without expiry
    pwmHoldTimeout = 16'h0014;
    u_node.send(SRC, 16'h0004, 16'h0000, 2'b01, 10'h3d0, 10'h000);
    sleepActive = 1'b1;
    cyc(3);
    `CHK("duty0", 10'h000, pulseOutput0Duty)
    `CHK("periphForceLow", 1'b1, periphForceLow)
    `CHK("spiForceHigh", 1'b1, spiForceHigh)
    `CHK("lineOe", 15'h580c, lineOe)
    `CHK("linePullUp", 15'h0002, linePullUp)
    `CHK("linePullDown", 15'h0001, linePullDown)
    cyc(40);
    `CHK("lineOut", 15'h0008, lineOut)
    sleepActive = 1'b0;
    cyc(3);
    `CHK("duty0", 10'h055, pulseOutput0Duty)
    `CHK("spiForceHigh", 1'b0, spiForceHigh)
    `CHK("lineOut", 15'h0008, lineOut)
    cyc(16);
    `CHK("lineOut", 15'h000c, lineOut)
    end_sim();
  end
  initial begin
    #80000;
    fail_count++;
    $display("Error watchdog expected end seen hang");
    end_sim();
  end
endmodule
